// >>> bench/rxhw_line_source.sv
// line source, clocks and pad pulls on the far side of the status pins
`timescale 1ns/100ps
module rxhw_line_source (
  input wire logic clk,
  input wire logic [7:0] pulls,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOeN,
  input wire logic mclkRun,
  input wire logic zNext,
  input wire logic [15:0] framePeriod,
  output logic [7:0] padLevel,
  output logic mclk = 1'h0,
  output logic wordClk = 1'h0,
  output logic frameTick = 1'h0,
  output logic zTick = 1'h0
);
  logic [15:0] gap = 16'h0;
  // a released pin settles to its pull, a driven pin shows the device
  assign padLevel = (pinOeN & pulls) | (~pinOeN & pinOut);
  // word clock runs free from time zero, phase unrelated to the core clock
  initial begin
    #73;
    forever #200 wordClk = ~wordClk;
  end
  // master clock stands still when stopped, so pin updates can be withheld
  always @(posedge clk) begin
    if (mclkRun) begin
      mclk <= ~mclk;
    end
    frameTick <= 1'h0;
    zTick <= 1'h0;
    if (framePeriod != 16'h0) begin
      gap <= gap + 16'h1;
      if (gap >= framePeriod - 16'h1) begin
        gap <= 16'h0;
        frameTick <= 1'h1;
        zTick <= zNext;
      end
    end
  end
endmodule : rxhw_line_source

// >>> bench/rxhw_status_pins_bench.sv
// self-checking bench of the receiver hardware-mode status pins
`timescale 1ns/100ps
`include "rxhw_defs.svh"
module rxhw_status_pins_bench;
  logic coreClk = 1'h0;
  logic rstN = 1'h0;
  logic [3:0] linePos = 4'h0;
  logic [1:0] rxSel = 2'h0, passSel = 2'h0;
  logic csBit = 1'h0, userBit = 1'h0, valBit = 1'h0, rxErr = 1'h0, nonAud = 1'h0;
  logic wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0;
  logic [3:0] wbAdr = 4'h0, wbSel = 4'h0;
  logic [31:0] wbDatWr = 32'h0, wbDatRd, rd;
  logic wbAck, mclk, wordClk, frameTick, zTick, lowPower, hwMode, pdType, valMode;
  logic fmtHi, fmtLo, emph, master, mclk128, rxLine, mclkRun = 1'h0, zNext = 1'h0;
  logic [7:0] pulls = 8'h0, pinIn, pinOut, pinOeN;
  logic [15:0] framePeriod = 16'h0;
  int miscompares = 0, totalChecks = 0;

  always #25 coreClk = ~coreClk;

  rxhw_status_pins u_rxhw_status_pins (.core_clk(coreClk), .rst_n(rstN),
    .lineInputPos(linePos), .receiverInputSelect(rxSel), .passthroughRouteSelect(passSel),
    .recoveredMasterClock(mclk), .outputWordClock(wordClk), .frameTick(frameTick),
    .zPreambleTick(zTick), .csBit(csBit), .userBit(userBit), .validityBit(valBit),
    .rxError(rxErr), .nonAudioDet(nonAud), .strapPinIn(pinIn), .strapPinOut(pinOut),
    .strapPinOeN(pinOeN), .receiverLine(rxLine), .lowPower(lowPower), .hwMode(hwMode),
    .phaseDetectorType(pdType), .validityErrorMode(valMode), .formatSelectHi(fmtHi),
    .formatSelectLo(fmtLo), .emphasisMatch(emph), .masterMode(master), .mclk128(mclk128),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbDatWr(wbDatWr),
    .wbSel(wbSel), .wbDatRd(wbDatRd), .wbAck(wbAck));

  rxhw_line_source u_rxhw_line_source (.clk(coreClk), .pulls(pulls), .pinOut(pinOut),
    .pinOeN(pinOeN), .mclkRun(mclkRun), .zNext(zNext), .framePeriod(framePeriod),
    .padLevel(pinIn), .mclk(mclk), .wordClk(wordClk), .frameTick(frameTick), .zTick(zTick));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge coreClk);
    #1;
  endtask : settle

  // the request stands until ack is seen at an edge, read data taken there
  task automatic wb(input logic we, input logic [3:0] adr, output logic [31:0] dr);
    int n;
    n = 0;
    @(posedge coreClk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    do begin
      @(posedge coreClk);
      n++;
    end while (wbAck !== 1'h1 && n < 20);
    dr = wbDatRd;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    wbWe <= 1'h0;
    chk("bus ack", 1, wbAck);
    @(posedge coreClk);
  endtask : wb

  task automatic testFlags(input logic plain);
    for (int i = 0; i < 4; i++) begin
      @(posedge coreClk);
      valBit <= i[0];
      rxErr <= i[1];
      nonAud <= i[0];
      settle(4);
      chk("error pin", i[1] | (i[0] & !plain), pinOut[1]);
      chk("non-audio pin", i[0], pinOut[2]);
    end
    @(posedge coreClk);
    valBit <= 1'h0;
    rxErr <= 1'h0;
  endtask : testFlags

  task automatic testStraps(input logic [7:0] p);
    @(posedge coreClk);
    rstN <= 1'h0;
    pulls <= p;
    settle(1);
    chk("low power", 1, lowPower);
    chk("pin enables", 8'hFF, pinOeN);
    chk("pin outputs", 0, pinOut);
    @(posedge coreClk);
    rstN <= 1'h1;
    settle(30);
    @(posedge coreClk);
    pulls <= ~p; // pulls move only after the strap window has shut
    settle(5);
    chk("hw mode", !p[7], hwMode);
    chk("phase detector", p[0], pdType);
    chk("validity mode", !p[1], valMode);
    chk("format hi", p[2], fmtHi);
    chk("emphasis", p[3], emph);
    chk("master", p[4], master);
    chk("format lo", p[5], fmtLo);
    chk("mclk 128", p[6], mclk128);
    chk("low power", 0, lowPower);
    wb(1'h0, `RXHW_REG_STATUS, rd);
    chk("status", {p[6], p[4], p[3], p[2], p[5], !p[1], p[0], !p[7]}, rd[7:0]);
    chk("state", p[7] ? 2 : 1, rd[11:10]);
    chk("pin enables", p[7] ? 8'hFF : 8'h80, pinOeN);
    if (!p[7]) begin
      testFlags(p[1]);
    end
    $display("strap test %h done", p);
  endtask : testStraps

  task automatic testMux;
    for (int s = 0; s < 4; s++) begin
      @(posedge coreClk);
      rxSel <= s[1:0];
      passSel <= 2'(3 - s);
      linePos <= 4'h1 << s;
      settle(6);
      chk("receiver line", 1, rxLine);
      chk("pass-through", 0, pinOut[0]);
      @(posedge coreClk);
      linePos <= ~(4'h1 << s);
      settle(6);
      chk("receiver line", 0, rxLine);
      chk("pass-through", 1, pinOut[0]);
    end
    @(posedge coreClk);
    passSel <= 2'h0;
    $display("mux test done");
  endtask : testMux

  // a new bit every half period: loading on one edge only would lag
  task automatic testSerial;
    for (int i = 0; i < 8; i++) begin
      @(wordClk);
      @(posedge coreClk);
      csBit <= i[0];
      userBit <= !i[0];
      settle(3);
      chk("status bit pin", i[0], pinOut[5]);
      chk("user bit pin", !i[0], pinOut[6]);
    end
    $display("serial test done");
  endtask : testSerial

  task automatic rate(input logic [15:0] per, input logic exp);
    @(posedge coreClk);
    framePeriod <= per;
    repeat (4) @(posedge frameTick);
    settle(3);
    chk("high rate pin", exp, pinOut[3]);
  endtask : rate

  // master clock is stopped during frame 18 only, so the fall must wait
  task automatic testBlock;
    @(posedge coreClk);
    framePeriod <= 16'h18;
    mclkRun <= 1'h1;
    zNext <= 1'h1;
    @(posedge zTick);
    @(posedge coreClk);
    zNext <= 1'h0;
    for (int k = 1; k < 21; k++) begin
      @(posedge coreClk);
      mclkRun <= (k != 18);
      @(posedge frameTick);
      settle(10);
      chk("block pin", (k >= 2 && k <= 18), pinOut[4]);
    end
    $display("block test done");
  endtask : testBlock

  task automatic testCount;
    @(posedge coreClk);
    rxErr <= 1'h1;
    repeat (3) @(posedge frameTick);
    @(posedge coreClk);
    rxErr <= 1'h0;
    wb(1'h0, `RXHW_REG_ERRCNT, rd);
    chk("error count", 3, rd);
    wb(1'h1, `RXHW_REG_ERRCNT, rd);
    wb(1'h0, `RXHW_REG_ERRCNT, rd);
    chk("cleared count", 0, rd);
    wb(1'h0, 4'h8, rd);
    chk("unmapped read", 0, rd);
    $display("counter test done");
  endtask : testCount

  task automatic results;
    $display("checks %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // whole run is near 6000 cycles; allow over six times that
  initial begin
    #2000000;
    miscompares++;
    $display("watchdog expired");
    results();
  end

  initial begin
    testStraps(8'hD5);
    testStraps(8'h2A);
    testStraps(8'h55);
    testMux();
    testSerial();
    rate(16'd227, 1'h1);
    rate(16'd300, 1'h1);
    rate(16'd417, 1'h0);
    rate(16'd300, 1'h0);
    $display("rate test done");
    testBlock();
    testCount();
    results();
  end
endmodule : rxhw_status_pins_bench

// >>> hw/rxhw_blk_if.sv
// frame events toward the block-start generator and its level back
`timescale 1ns/100ps
interface rxhw_blk_if (
  input wire logic clk,
  input wire logic rstN
);
  logic frameTick;
  logic zTick;
  logic blockLevel;
  modport gen (input clk, input rstN, input frameTick, input zTick, output blockLevel);
  modport user (input clk, input rstN, output frameTick, output zTick, input blockLevel);
endinterface : rxhw_blk_if

// >>> hw/rxhw_block_gen.sv
// channel status block-start level, counted in frames from the Z preamble
`timescale 1ns/100ps
`include "rxhw_defs.svh"
module rxhw_block_gen import rxhw_pkg::*; (
  rxhw_blk_if.gen link
);
  rxhw_blk_t state_r;
  rxhw_blk_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (link.frameTick) begin
      if (link.zTick) begin
        state_nxt.frameCnt = 8'h00;
        state_nxt.seen = 1'b1;
      end else if (state_r.frameCnt != 8'(`RXHW_BLK_FRAMES - 1)) begin
        state_nxt.frameCnt = state_r.frameCnt + 8'h01;
      end
    end
    // window opens two frames after Z and lasts sixteen frames
    state_nxt.level = state_nxt.seen &&
        (state_nxt.frameCnt >= 8'(`RXHW_BLK_DELAY)) &&
        (state_nxt.frameCnt < 8'(`RXHW_BLK_DELAY + `RXHW_BLK_LEN));
  end

  always_ff @(posedge link.clk or negedge link.rstN) begin
    if (!link.rstN) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign link.blockLevel = state_r.level;

  a_blk_rise: assert property (@(posedge link.clk) disable iff (!link.rstN)
    (link.frameTick && !link.zTick && state_r.seen && state_r.frameCnt == 8'h01)
    |=> link.blockLevel)
    else $error("block level did not rise two frames after Z");

  a_blk_window: assert property (@(posedge link.clk) disable iff (!link.rstN)
    link.blockLevel |-> (state_r.frameCnt >= 8'(`RXHW_BLK_DELAY) &&
        state_r.frameCnt < 8'(`RXHW_BLK_DELAY + `RXHW_BLK_LEN)))
    else $error("block level outside its sixteen frame window");

  a_blk_fall: assert property (@(posedge link.clk) disable iff (!link.rstN)
    (link.frameTick && !link.zTick &&
        state_r.frameCnt == 8'(`RXHW_BLK_DELAY + `RXHW_BLK_LEN - 1))
    |=> !link.blockLevel)
    else $error("block level did not fall after sixteen frames");
endmodule : rxhw_block_gen

// >>> hw/rxhw_defs.svh
// constants of the receiver hardware-mode status pin block
`ifndef RXHW_DEFS_SVH
`define RXHW_DEFS_SVH

// index of each shared strap / status pin in the pin vectors
`define RXHW_PIN_PASS 0
`define RXHW_PIN_ERR 1
`define RXHW_PIN_NONAUD 2
`define RXHW_PIN_HIRATE 3
`define RXHW_PIN_BLK 4
`define RXHW_PIN_CS 5
`define RXHW_PIN_USER 6
`define RXHW_PIN_SER 7

// output enables, active low
`define RXHW_PINS_RELEASED 8'hFF
`define RXHW_PINS_DRIVEN 8'h80

// core clock
`define RXHW_CLK_HZ 20000000

// strap sampling window after reset release
`define RXHW_STRAP_NS 1000
`define RXHW_STRAP_CYC ((`RXHW_STRAP_NS * (`RXHW_CLK_HZ / 1000000) + 999) / 1000)

// sample rate thresholds of the high-rate flag
`define RXHW_HI_RATE_HZ 88100
`define RXHW_LO_RATE_HZ 48000
`define RXHW_HI_CYC (`RXHW_CLK_HZ / `RXHW_HI_RATE_HZ)
`define RXHW_LO_CYC (`RXHW_CLK_HZ / `RXHW_LO_RATE_HZ)

// channel status block framing
`define RXHW_BLK_FRAMES 192
`define RXHW_BLK_DELAY 2
`define RXHW_BLK_LEN 16

// wishbone register byte offsets
`define RXHW_REG_STATUS 4'h0
`define RXHW_REG_ERRCNT 4'h4

`endif

// >>> hw/rxhw_pkg.sv
// types of the receiver hardware-mode status pin block
package rxhw_pkg;

  typedef enum logic [1:0] {RXHW_ST_STRAP, RXHW_ST_RUN, RXHW_ST_SOFT} rxhw_phase_t;

  typedef struct packed {
    rxhw_phase_t st;
    logic [4:0] strapCnt;
    logic hwMode;
    logic pdType;
    logic valMode;
    logic fmtHi;
    logic fmtLo;
    logic emph;
    logic master;
    logic mclk128;
    logic rmckPrev;
    logic olrckPrev;
    logic [9:0] ratePeriod;
    logic [7:0] pinOut;
    logic [7:0] pinOeN;
    logic rxLine;
    logic lowPower;
    logic [15:0] errCnt;
    logic wbAck;
    logic [31:0] wbDat;
  } rxhw_core_t;

  typedef struct packed {
    logic [7:0] frameCnt;
    logic seen;
    logic level;
  } rxhw_blk_t;

endpackage : rxhw_pkg

// >>> hw/rxhw_status_pins.sv
// receiver hardware-mode straps, input multiplexers and status pins
`timescale 1ns/100ps
`include "rxhw_defs.svh"

// Functional notes
// - pass-through pin copies the selected line input, squared, not de-jittered
// - pass-through pin level at reset picks the phase detector type
// - error pin strapped low reports validity-qualified errors, high plain errors
// - non-audio pin low for valid linear PCM, high otherwise
// - non-audio pin level at reset is the upper format select bit
// - high-rate pin 0 at or below 48 kHz, 1 from 88.1 kHz
// - high-rate pin level at reset sets emphasis audio match
// - block-start high two frames after Z, for 16 frames, then low
// - block-start pin changes only on recovered master clock rising edges
// - block-start pin level at reset picks serial port master or slave
// - channel status bits shift out on both word clock edges
// - channel status pin level at reset is the lower format select bit
// - user bits shift out on both word clock edges
// - user pin level at reset picks master clock 256 or 128 times Fs
// - reset low means low power and all state cleared
// - receiver takes one of four line inputs by a two-bit select
// - serial audio out pulled low at reset enters hardware mode
module rxhw_status_pins import rxhw_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] lineInputPos,
  input wire logic [1:0] receiverInputSelect,
  input wire logic [1:0] passthroughRouteSelect,
  input wire logic recoveredMasterClock,
  input wire logic outputWordClock,
  input wire logic frameTick,
  input wire logic zPreambleTick,
  input wire logic csBit,
  input wire logic userBit,
  input wire logic validityBit,
  input wire logic rxError,
  input wire logic nonAudioDet,
  input wire logic [7:0] strapPinIn,
  output logic [7:0] strapPinOut,
  output logic [7:0] strapPinOeN,
  output logic receiverLine,
  output logic lowPower,
  output logic hwMode,
  output logic phaseDetectorType,
  output logic validityErrorMode,
  output logic formatSelectHi,
  output logic formatSelectLo,
  output logic emphasisMatch,
  output logic masterMode,
  output logic mclk128,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbAdr,
  input wire logic [31:0] wbDatWr,
  input wire logic [3:0] wbSel,
  output logic [31:0] wbDatRd,
  output logic wbAck
);

  // ****************************************
  // reset release and input synchronisers
  // ****************************************
  logic rstSyncN;
  logic [17:0] syncQ;
  logic [3:0] lineS;
  logic [1:0] rxSelS;
  logic [1:0] txSelS;
  logic rmckS;
  logic olrckS;
  logic [7:0] pinS;

  // reset asserts at once but releases on the clock
  rxhw_sync2 #(.W(1)) u_rst_sync (
    .clk(core_clk),
    .rstN(rst_n),
    .d(1'b1),
    .q(rstSyncN)
  );

  // every pin and both foreign clocks cross through two flops
  rxhw_sync2 #(.W(18)) u_pin_sync (
    .clk(core_clk),
    .rstN(rstSyncN),
    .d({strapPinIn, outputWordClock, recoveredMasterClock,
        passthroughRouteSelect, receiverInputSelect, lineInputPos}),
    .q(syncQ)
  );

  assign {pinS, olrckS, rmckS, txSelS, rxSelS, lineS} = syncQ;

  // ****************************************
  // block-start generator
  // ****************************************
  rxhw_blk_if blk (
    .clk(core_clk),
    .rstN(rstSyncN)
  );

  assign blk.frameTick = frameTick;
  assign blk.zTick = zPreambleTick;

  rxhw_block_gen u_block_gen (
    .link(blk.gen)
  );

  // ****************************************
  // core state
  // ****************************************
  rxhw_core_t state_r;
  rxhw_core_t state_nxt;
  logic rmckRise;
  logic olrckEdge;
  logic wbReq;
  logic errEvt;
  logic errClr;
  logic strapLast;

  assign rmckRise = rmckS & ~state_r.rmckPrev;
  assign olrckEdge = olrckS ^ state_r.olrckPrev;
  assign wbReq = wbCyc & wbStb;
  assign errEvt = frameTick & rxError;
  // a write lands on the edge where the master sees ack
  assign errClr = wbReq & wbWe & state_r.wbAck & wbSel[0] &
      (wbAdr == `RXHW_REG_ERRCNT);
  assign strapLast = (state_r.st == RXHW_ST_STRAP) &&
      (state_r.strapCnt == 5'(`RXHW_STRAP_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    state_nxt.lowPower = 1'b0;
    state_nxt.rmckPrev = rmckS;
    state_nxt.olrckPrev = olrckS;
    state_nxt.rxLine = lineS[rxSelS];

    // frame period in core cycles, saturating so a dead line reads as slow
    if (frameTick) begin
      state_nxt.ratePeriod = 10'h000;
    end else if (state_r.ratePeriod != 10'h3FF) begin
      state_nxt.ratePeriod = state_r.ratePeriod + 10'h001;
    end

    case (state_r.st)
      RXHW_ST_STRAP: begin
        // pins released so the external pull resistors set their level
        state_nxt.pinOeN = `RXHW_PINS_RELEASED;
        state_nxt.pinOut = 8'h00;
        state_nxt.strapCnt = state_r.strapCnt + 5'h01;
        if (strapLast) begin
          state_nxt.pdType = pinS[`RXHW_PIN_PASS];
          state_nxt.valMode = ~pinS[`RXHW_PIN_ERR];
          state_nxt.fmtHi = pinS[`RXHW_PIN_NONAUD];
          state_nxt.emph = pinS[`RXHW_PIN_HIRATE];
          state_nxt.master = pinS[`RXHW_PIN_BLK];
          state_nxt.fmtLo = pinS[`RXHW_PIN_CS];
          state_nxt.mclk128 = pinS[`RXHW_PIN_USER];
          state_nxt.hwMode = ~pinS[`RXHW_PIN_SER];
          if (!pinS[`RXHW_PIN_SER]) begin
            state_nxt.st = RXHW_ST_RUN;
            state_nxt.pinOeN = `RXHW_PINS_DRIVEN;
          end else begin
            state_nxt.st = RXHW_ST_SOFT;
          end
        end
      end
      RXHW_ST_RUN: begin
        // squared copy only, jitter passes straight through
        state_nxt.pinOut[`RXHW_PIN_PASS] = lineS[txSelS];
        state_nxt.pinOut[`RXHW_PIN_ERR] = rxError | (state_r.valMode & validityBit);
        state_nxt.pinOut[`RXHW_PIN_NONAUD] = nonAudioDet;
        if (frameTick) begin
          // between the thresholds the flag keeps its last value
          if (state_r.ratePeriod < 10'(`RXHW_HI_CYC)) begin
            state_nxt.pinOut[`RXHW_PIN_HIRATE] = 1'b1;
          end else if (state_r.ratePeriod >= 10'(`RXHW_LO_CYC - 1)) begin
            state_nxt.pinOut[`RXHW_PIN_HIRATE] = 1'b0;
          end
        end
        if (rmckRise) begin
          state_nxt.pinOut[`RXHW_PIN_BLK] = blk.blockLevel;
        end
        if (olrckEdge) begin
          state_nxt.pinOut[`RXHW_PIN_CS] = csBit;
          state_nxt.pinOut[`RXHW_PIN_USER] = userBit;
        end
      end
      RXHW_ST_SOFT: begin
        // control-port mode lives elsewhere, pins stay released
        state_nxt.pinOeN = `RXHW_PINS_RELEASED;
        state_nxt.pinOut = 8'h00;
      end
      default: begin
        state_nxt.st = RXHW_ST_STRAP;
      end
    endcase

    // error frame counter, a clear with a new error in the same cycle leaves a count of one
    if (errEvt) begin
      if (errClr) begin
        state_nxt.errCnt = 16'h0001;
      end else if (state_r.errCnt != 16'hFFFF) begin
        state_nxt.errCnt = state_r.errCnt + 16'h0001;
      end
    end else if (errClr) begin
      state_nxt.errCnt = 16'h0000;
    end

    // wishbone slave, one wait state, unmapped reads return zero
    state_nxt.wbAck = wbReq & ~state_r.wbAck;
    state_nxt.wbDat = 32'h0000_0000;
    if (wbReq && !state_r.wbAck && !wbWe) begin
      case (wbAdr)
        `RXHW_REG_STATUS: begin
          state_nxt.wbDat = {20'h0_0000, 2'(state_r.st),
              state_r.pinOut[`RXHW_PIN_BLK], state_r.pinOut[`RXHW_PIN_HIRATE],
              state_r.mclk128, state_r.master, state_r.emph, state_r.fmtHi,
              state_r.fmtLo, state_r.valMode, state_r.pdType, state_r.hwMode};
        end
        `RXHW_REG_ERRCNT: begin
          state_nxt.wbDat = {16'h0000, state_r.errCnt};
        end
        default: begin
          state_nxt.wbDat = 32'h0000_0000;
        end
      endcase
    end
  end

  // low power flag and cleared state while reset is held
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_r <= '{st: RXHW_ST_STRAP, pinOeN: `RXHW_PINS_RELEASED,
          lowPower: 1'b1, default: '0};
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign strapPinOut = state_r.pinOut;
  assign strapPinOeN = state_r.pinOeN;
  assign receiverLine = state_r.rxLine;
  assign lowPower = state_r.lowPower;
  assign hwMode = state_r.hwMode;
  assign phaseDetectorType = state_r.pdType;
  assign validityErrorMode = state_r.valMode;
  assign formatSelectHi = state_r.fmtHi;
  assign formatSelectLo = state_r.fmtLo;
  assign emphasisMatch = state_r.emph;
  assign masterMode = state_r.master;
  assign mclk128 = state_r.mclk128;
  assign wbDatRd = state_r.wbDat;
  assign wbAck = state_r.wbAck;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (!rstSyncN);

  sequence s_strap_done;
    (state_r.st == RXHW_ST_STRAP) ##1 (state_r.st != RXHW_ST_STRAP);
  endsequence

  sequence s_running;
    (state_r.st == RXHW_ST_RUN) ##1 (state_r.st == RXHW_ST_RUN);
  endsequence

  a_rx_route: assert property (
    1'b1 |=> receiverLine == $past(lineS[rxSelS]))
    else $error("receiver line does not follow its select");

  a_pass_route: assert property (
    (state_r.st == RXHW_ST_RUN) |=> strapPinOut[`RXHW_PIN_PASS] == $past(lineS[txSelS]))
    else $error("pass-through pin does not follow its select");

  a_strap_format: assert property (
    s_strap_done |-> (formatSelectHi == $past(pinS[`RXHW_PIN_NONAUD]) &&
        formatSelectLo == $past(pinS[`RXHW_PIN_CS])))
    else $error("format select not taken from its straps");

  a_strap_misc: assert property (
    s_strap_done |-> (phaseDetectorType == $past(pinS[`RXHW_PIN_PASS]) &&
        emphasisMatch == $past(pinS[`RXHW_PIN_HIRATE]) &&
        masterMode == $past(pinS[`RXHW_PIN_BLK]) &&
        mclk128 == $past(pinS[`RXHW_PIN_USER])))
    else $error("configuration strap latched wrongly");

  a_hw_enter: assert property (
    s_strap_done |-> (hwMode == !$past(pinS[`RXHW_PIN_SER])) &&
        (strapPinOeN == (hwMode ? `RXHW_PINS_DRIVEN : `RXHW_PINS_RELEASED)))
    else $error("hardware mode entry or pin drive wrong");

  a_strap_hold: assert property (
    (state_r.st != RXHW_ST_STRAP) |=> $stable({hwMode, phaseDetectorType,
        validityErrorMode, formatSelectHi, formatSelectLo, emphasisMatch,
        masterMode, mclk128}))
    else $error("latched strap changed after release");

  a_err_mode: assert property (
    (state_r.st == RXHW_ST_RUN) |=> strapPinOut[`RXHW_PIN_ERR] ==
        ($past(rxError) | ($past(validityErrorMode) & $past(validityBit))))
    else $error("error pin ignores its strap mode");

  a_non_audio: assert property (
    (state_r.st == RXHW_ST_RUN) |=> strapPinOut[`RXHW_PIN_NONAUD] == $past(nonAudioDet))
    else $error("non-audio pin does not track the detector");

  a_rate_high: assert property (
    (state_r.st == RXHW_ST_RUN && frameTick &&
        state_r.ratePeriod < 10'(`RXHW_HI_CYC)) |=> strapPinOut[`RXHW_PIN_HIRATE])
    else $error("high-rate flag low at a fast frame rate");

  a_rate_low: assert property (
    (state_r.st == RXHW_ST_RUN && frameTick &&
        state_r.ratePeriod >= 10'(`RXHW_LO_CYC - 1)) |=> !strapPinOut[`RXHW_PIN_HIRATE])
    else $error("high-rate flag high at a slow frame rate");

  a_blk_recovered_master_clock: assert property (
    (s_running ##0 $changed(strapPinOut[`RXHW_PIN_BLK])) |-> $past(rmckRise))
    else $error("block-start pin moved off a master clock rise");

  a_cs_edge: assert property (
    (state_r.st == RXHW_ST_RUN && olrckEdge) |=>
        (strapPinOut[`RXHW_PIN_CS] == $past(csBit) &&
        strapPinOut[`RXHW_PIN_USER] == $past(userBit)))
    else $error("channel status or user bit not loaded on word clock edge");

  a_cs_still: assert property (
    (s_running ##0 !$past(olrckEdge)) |->
        $stable(strapPinOut[`RXHW_PIN_USER:`RXHW_PIN_CS]))
    else $error("channel status or user pin moved between edges");

  a_low_power: assert property (@(posedge core_clk) disable iff (!rst_n)
    !rstSyncN |-> (lowPower && strapPinOeN == `RXHW_PINS_RELEASED))
    else $error("low power or released pins missing in reset");

  a_ack_pulse: assert property (
    wbAck |=> !wbAck)
    else $error("bus ack longer than one cycle");

endmodule : rxhw_status_pins

// >>> hw/rxhw_sync2.sv
// two flip-flop synchroniser, parameterised width
`timescale 1ns/100ps
module rxhw_sync2 import rxhw_pkg::*; #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rxhw_sync_t;

  rxhw_sync_t state_r;
  rxhw_sync_t state_nxt;

  // first stage feeds only the second stage
  always_comb begin
    state_nxt.s1 = d;
    state_nxt.s2 = state_r.s1;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign q = state_r.s2;
endmodule : rxhw_sync2
